// >>> bench/tb_cpu_increment_or_shift_branch_ops.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_increment_or_shift_branch_ops
	import iob_pkg::*;
;
	// ****************************************
	// Stimulus, outputs and reference state
	// ****************************************
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	iob_req_s req = '0;
	logic [7:0] fdata = 8'h00;
	logic [6:0] latch = 7'h00;
	logic req_ready, zero_flag, carry_flag, fwr_en, nop_cycle;
	logic [7:0] accum, fwr_data;
	logic [6:0] fwr_addr;
	logic [14:0] pc;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	logic [7:0] m_acc = 8'h00;
	logic m_z = 1'b0;
	logic m_c = 1'b0;
	logic [14:0] m_pc = 15'h0000;
	iob_op_e ops[6] = '{IOB_OP_INCSZ, IOB_OP_INC, IOB_OP_BRANCH, IOB_OP_ORLIT, IOB_OP_ORFILE, IOB_OP_LSL};

	iob_core uut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .fdata(fdata), .latch(latch),
		.req_ready(req_ready), .accum(accum), .zero_flag(zero_flag), .carry_flag(carry_flag), .pc(pc),
		.fwr_en(fwr_en), .fwr_addr(fwr_addr), .fwr_data(fwr_data), .nop_cycle(nop_cycle));

	// Clock and hang guard
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			close_out();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Expected result of one operation
	function automatic logic [7:0] exp_res(input iob_op_e op, input logic [7:0] acc, input logic [10:0] k,
		input logic [7:0] fd);
		case (op)
			IOB_OP_INCSZ, IOB_OP_INC: exp_res = fd + 8'h01;
			IOB_OP_ORLIT: exp_res = acc | k[7:0];
			IOB_OP_ORFILE: exp_res = acc | fd;
			IOB_OP_LSL: exp_res = {fd[6:0], 1'b0};
			default: exp_res = 8'h00;
		endcase
	endfunction

	// Issues one instruction, predicts its effect and checks it; valid stays up through a bubble
	task automatic issue(input iob_op_e op, input logic d, input logic [6:0] fa, input logic [10:0] k,
		input logic [7:0] fd, input logic [6:0] la);
		logic [7:0] r;
		logic bub;
		logic we;
		r = exp_res(op, m_acc, k, fd);
		bub = (op == IOB_OP_BRANCH) || (op == IOB_OP_INCSZ && r == 8'h00);
		req = '{1'b1, op, d, fa, k};
		fdata = fd;
		latch = la;
		chk(req_ready, 1'b1);
		m_pc = (op == IOB_OP_BRANCH) ? {la[6:3], k} : m_pc + 15'h1;
		if (op == IOB_OP_LSL) m_c = fd[7];
		if (op != IOB_OP_INCSZ && op != IOB_OP_BRANCH) m_z = (r == 8'h00);
		we = d && op != IOB_OP_BRANCH && op != IOB_OP_ORLIT;
		if (!we && op != IOB_OP_BRANCH) m_acc = r;
		@(negedge clk_sys);
		chk(accum, m_acc);
		chk(zero_flag, m_z);
		chk(carry_flag, m_c);
		chk(pc, m_pc);
		chk(fwr_en, we);
		if (we) chk({fwr_addr, fwr_data}, {fa, r});
		chk(nop_cycle, bub);
		chk(req_ready, !bub);
		if (bub) begin
			if (op == IOB_OP_INCSZ) m_pc = m_pc + 15'h1;
			@(negedge clk_sys);
			chk({fwr_en, pc}, {1'b0, m_pc});
			chk(nop_cycle, 1'b0);
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(86));
		repeat (12) @(negedge clk_sys);
		reset_n = 1'b1;
		issue(IOB_OP_INCSZ, 1'b1, 7'h7f, 11'h000, 8'hff, 7'h00);
		issue(IOB_OP_INCSZ, 1'b0, 7'h01, 11'h000, 8'hfe, 7'h00);
		issue(IOB_OP_INC, 1'b0, 7'h02, 11'h000, 8'hff, 7'h00);
		issue(IOB_OP_ORLIT, 1'b1, 7'h00, 11'h700, 8'h00, 7'h00);
		issue(IOB_OP_LSL, 1'b0, 7'h03, 11'h000, 8'h80, 7'h00);
		issue(IOB_OP_BRANCH, 1'b0, 7'h00, 11'h7ff, 8'h00, 7'h7f);
		issue(IOB_OP_BRANCH, 1'b0, 7'h00, 11'h000, 8'h00, 7'h47);
		issue(IOB_OP_ORFILE, 1'b1, 7'h05, 11'h000, 8'h00, 7'h00);
		// Reset in mid-run: all state back to its reset value
		req.valid = 1'b0;
		reset_n = 1'b0;
		@(negedge clk_sys);
		chk({accum, zero_flag, carry_flag, fwr_en, nop_cycle, req_ready}, {8'h00, 5'h01});
		chk(pc, 15'h0000);
		reset_n = 1'b1;
		m_acc = 8'h00;
		m_z = 1'b0;
		m_c = 1'b0;
		m_pc = 15'h0000;
		// Random mix of every operation
		for (int i = 0; i < 400; i++) begin
			issue(ops[$urandom % 6], 1'($urandom), 7'($urandom), 11'($urandom), 8'($urandom), 7'($urandom));
		end
		req.valid = 1'b0;
		@(negedge clk_sys);
		chk(pc, m_pc);
		close_out();
	end
endmodule
`default_nettype wire

// >>> src/iob_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Seven-bit file address; dest 0 writes accumulator, dest 1 writes file register.
// - Increment-skip adds one, stores at destination, leaves all flags alone.
// - Increment-skip with zero result squashes the next instruction, two cycles.
// - Plain increment adds one, stores at destination, updates zero only.
// - Branch loads its 11-bit literal into program counter bits 10:0.
// - Branch fills program counter bits 14:11 from latch bits 6:3.
// - Branch takes two cycles and leaves all flags alone.
// - OR-literal ORs accumulator with 8-bit literal into accumulator, updates zero.
// - OR-file ORs accumulator with file register into destination, updates zero.
// - Left shift: bit 7 to carry, 6:0 to 7:1, zero into bit 0.
module iob_core
	import iob_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Decoder request
	input wire iob_req_s req,
	input wire logic [IOB_DATA_W-1:0] fdata,
	input wire logic [IOB_LATCH_W-1:0] latch,
	// Decoder handshake
	output logic req_ready,
	// Architectural state
	output logic [IOB_DATA_W-1:0] accum,
	output logic zero_flag,
	output logic carry_flag,
	output logic [IOB_PC_W-1:0] pc,
	// File register write port
	output logic fwr_en,
	output logic [IOB_FADDR_W-1:0] fwr_addr,
	output logic [IOB_DATA_W-1:0] fwr_data,
	// Marks a cycle spent as a no-operation
	output logic nop_cycle
);
	iob_state_s s_r, s_nxt;
	logic [IOB_DATA_W-1:0] res;
	logic res_zero;
	logic take;

	// ********************************************************************
	// Next state
	// ********************************************************************
	// Requests are refused while a bubble cycle is being spent
	assign req_ready = (s_r.st == IOB_ST_RUN);
	assign take = req.valid && req_ready;

	// Result, flags, destination and sequencing for one instruction
	always_comb begin
		s_nxt = s_r;
		s_nxt.fwr = 1'b0;
		s_nxt.squash = 1'b0;
		res = IOB_ZERO;
		unique case (req.op)
			IOB_OP_INCSZ, IOB_OP_INC: res = fdata + IOB_ONE;
			IOB_OP_ORLIT: res = s_r.accum | req.lit[IOB_DATA_W-1:0];
			IOB_OP_ORFILE: res = s_r.accum | fdata;
			IOB_OP_LSL: res = {fdata[IOB_DATA_W-2:0], 1'b0};
			IOB_OP_BRANCH: res = IOB_ZERO;
			default: res = IOB_ZERO;
		endcase
		// One zero test serves every flag-setting operation
		res_zero = (res == IOB_ZERO);
		unique case (s_r.st)
			IOB_ST_RUN: begin
				if (take) begin
					// Each taken instruction moves the fetch address on by one; a branch loads its target instead
					s_nxt.pc = s_r.pc + 15'h0001;
					if (req.op == IOB_OP_BRANCH) begin
						s_nxt.pc = {latch[IOB_LATCH_HI:IOB_LATCH_LO], req.lit};
						s_nxt.st = IOB_ST_BUBBLE;
					end else if (req.op == IOB_OP_ORLIT) begin
						s_nxt.accum = res;
						s_nxt.zero = res_zero;
					end else begin
						if (req.dest == IOB_DEST_W) begin
							s_nxt.accum = res;
						end else begin
							s_nxt.fwr = 1'b1;
							s_nxt.fwaddr = req.faddr;
							s_nxt.fwdata = res;
						end
						if (req.op != IOB_OP_INCSZ) begin
							s_nxt.zero = res_zero;
						end
						if (req.op == IOB_OP_LSL) begin
							s_nxt.carry = fdata[IOB_DATA_W-1];
						end
						if (req.op == IOB_OP_INCSZ && res_zero) begin
							s_nxt.st = IOB_ST_BUBBLE;
							s_nxt.squash = 1'b1;
						end
					end
				end
			end
			IOB_ST_BUBBLE: begin
				// Fetched instruction discarded; advance past it unless branching
				s_nxt.st = IOB_ST_RUN;
				if (s_r.squash) begin
					s_nxt.pc = s_r.pc + 15'h0001;
				end
			end
		endcase
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_r <= '{st: IOB_ST_RUN, accum: IOB_ZERO, zero: 1'b0, carry: 1'b0, pc: IOB_PC_RST,
				fwr: 1'b0, fwaddr: 7'h00, fwdata: IOB_ZERO, squash: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state
	assign accum = s_r.accum;
	assign zero_flag = s_r.zero;
	assign carry_flag = s_r.carry;
	assign pc = s_r.pc;
	assign fwr_en = s_r.fwr;
	assign fwr_addr = s_r.fwaddr;
	assign fwr_data = s_r.fwdata;
	assign nop_cycle = (s_r.st == IOB_ST_BUBBLE);

	// ********************************************************************
	// Checks
	// ********************************************************************
	incsz_flags_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ |=> $stable(zero_flag) && $stable(carry_flag))
		else $error("increment-skip changed a flag");
	incsz_skip_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ && fdata == 8'hff |=> nop_cycle ##1 !nop_cycle)
		else $error("increment-skip to zero did not squash one cycle");
	incsz_noskip_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ && fdata != 8'hff |=> !nop_cycle)
		else $error("increment-skip skipped on nonzero");
	inc_dest_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INC && req.dest |=> fwr_en && fwr_data == $past(fdata) + 8'h01)
		else $error("increment to file wrong");
	branch_pc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_BRANCH |=> pc == {$past(latch[6:3]), $past(req.lit)})
		else $error("branch target wrong");
	branch_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_BRANCH |=> !req_ready && $stable(zero_flag) ##1 req_ready)
		else $error("branch not two cycles");
	orlit_acc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_ORLIT |=> accum == ($past(accum) | $past(req.lit[7:0])))
		else $error("or-literal result wrong");
	orfile_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_ORFILE |=> zero_flag == (($past(accum) | $past(fdata)) == 8'h00))
		else $error("or-file zero flag wrong");
	lsl_carry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_LSL && !req.dest |=> carry_flag == $past(fdata[7]) && accum[0] == 1'b0)
		else $error("left shift wrong");

	// ********************************************************************
	// Checks on destination and stored value
	// ********************************************************************
	// Increment-skip stores its sum at the chosen destination
	incsz_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ && req.dest |=> fwr_en && fwr_data == $past(fdata) + 8'h01)
		else $error("increment-skip store wrong");
	incsz_acc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ && !req.dest |=> !fwr_en && accum == $past(fdata) + 8'h01)
		else $error("increment-skip to accumulator wrong");
	// A file write goes to the address that the instruction names
	write_addr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.dest && req.op != IOB_OP_BRANCH && req.op != IOB_OP_ORLIT
		|=> fwr_en && fwr_addr == $past(req.faddr))
		else $error("file write address wrong");
	// Accumulator destinations, branches and or-literal never touch the file
	no_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && (!req.dest || req.op == IOB_OP_BRANCH || req.op == IOB_OP_ORLIT) |=> !fwr_en)
		else $error("file write without file destination");
	// Or-file into the file leaves the accumulator as it was
	orfile_dest_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_ORFILE && req.dest
		|=> fwr_data == ($past(accum) | $past(fdata)) && $stable(accum))
		else $error("or-file store wrong");
	// Shift into the file: data moved up one place, top bit into carry
	lsl_data_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_LSL && req.dest
		|=> fwr_data == {$past(fdata[6:0]), 1'b0} && carry_flag == $past(fdata[7]))
		else $error("left shift store wrong");

	// ********************************************************************
	// Checks on flags
	// ********************************************************************
	// Plain increment: zero follows the sum, carry is left alone
	inc_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INC |=> zero_flag == (($past(fdata) + 8'h01) == 8'h00))
		else $error("increment zero flag wrong");
	inc_carry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INC |=> $stable(carry_flag))
		else $error("increment changed carry");
	// Or-literal: zero follows the new accumulator
	orlit_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_ORLIT |=> zero_flag == (accum == 8'h00))
		else $error("or-literal zero flag wrong");
	// Or-file never touches carry
	orfile_carry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_ORFILE |=> $stable(carry_flag))
		else $error("or-file changed carry");
	// Shift: zero follows the seven bits that stay in the result
	lsl_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_LSL |=> zero_flag == ($past(fdata[6:0]) == 7'h00))
		else $error("left shift zero flag wrong");

	// ********************************************************************
	// Checks on sequencing
	// ********************************************************************
	// Branch leaves flags, accumulator and file untouched
	branch_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_BRANCH
		|=> $stable(zero_flag) && $stable(carry_flag) && $stable(accum) && !fwr_en)
		else $error("branch changed state");
	// Upper target bits come from the latch and hold through the bubble
	branch_hi_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_BRANCH |=> pc[14:11] == $past(latch[6:3]) ##1 $stable(pc))
		else $error("branch upper target wrong");
	// A skip moves the fetch address on twice
	skip_pc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op == IOB_OP_INCSZ && fdata == 8'hff |=> ##1 pc == $past(pc, 2) + 15'h0002)
		else $error("skip did not pass the next instruction");
	// Anything but a skip or a branch moves it on once and is ready again at once
	pc_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		take && req.op != IOB_OP_BRANCH && !(req.op == IOB_OP_INCSZ && fdata == 8'hff)
		|=> pc == $past(pc) + 15'h0001 && req_ready)
		else $error("fetch address step wrong");
	// A bubble never lasts more than one cycle
	nop_once_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		nop_cycle |=> !nop_cycle)
		else $error("bubble longer than one cycle");
	// Reset clears the whole state
	reset_state_a: assert property (@(posedge clk_sys)
		!reset_n |=> pc == IOB_PC_RST && accum == IOB_ZERO && !zero_flag && !carry_flag && !fwr_en && !nop_cycle)
		else $error("state not cleared by reset");
endmodule
`default_nettype wire

// >>> src/iob_pkg.sv
`default_nettype none
package iob_pkg;
	// ********************************************************************
	// Widths and operand ranges
	// ********************************************************************
	localparam int IOB_DATA_W = 8;
	localparam int IOB_FADDR_W = 7;
	localparam int IOB_PC_W = 15;
	localparam int IOB_BRLIT_W = 11;
	localparam int IOB_LATCH_W = 7;
	// Latch field that feeds the upper program counter bits
	localparam int IOB_LATCH_HI = 6;
	localparam int IOB_LATCH_LO = 3;
	localparam logic IOB_DEST_W = 1'b0;
	localparam logic IOB_DEST_F = 1'b1;
	localparam logic [7:0] IOB_ZERO = 8'h00;
	localparam logic [7:0] IOB_ONE = 8'h01;
	localparam logic [14:0] IOB_PC_RST = 15'h0000;

	// ********************************************************************
	// Operation select, one-hot
	// ********************************************************************
	typedef enum logic [5:0] {
		IOB_OP_INCSZ = 6'h01,
		IOB_OP_INC = 6'h02,
		IOB_OP_BRANCH = 6'h04,
		IOB_OP_ORLIT = 6'h08,
		IOB_OP_ORFILE = 6'h10,
		IOB_OP_LSL = 6'h20
	} iob_op_e;

	// ********************************************************************
	// Sequencer states, one-hot
	// ********************************************************************
	typedef enum logic [1:0] {
		IOB_ST_RUN = 2'h1,
		IOB_ST_BUBBLE = 2'h2
	} iob_state_e;

	// Instruction request from the decoder
	typedef struct packed {
		logic valid;
		iob_op_e op;
		logic dest;
		logic [6:0] faddr;
		logic [10:0] lit;
	} iob_req_s;

	// Whole state of the block
	typedef struct packed {
		iob_state_e st;
		logic [7:0] accum;
		logic zero;
		logic carry;
		logic [14:0] pc;
		logic fwr;
		logic [6:0] fwaddr;
		logic [7:0] fwdata;
		logic squash;
	} iob_state_s;
endpackage
`default_nettype wire
